/* core/scss_clock_select.sv */
// system clock source selection, start-up gating and pin functions
`timescale 1ns/1ps
module scss_clock_select
    import scss_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [2:0] OSC_MODE_CONFIG_FIELD,
    input wire logic CONFIG_PLL_ENABLE,
    input wire logic CLOCK_OUTPUT_ENABLE_N,
    input wire logic POWER_UP_TIMER_CFG,
    input wire logic POWER_UP_TIMER_DONE,
    input wire logic [1:0] SYS_CLK_SELECT_FIELD,
    input wire logic SOFTWARE_PLL_ENABLE,
    input wire logic [5:0] OSCILLATOR_TUNING_REG,
    input wire logic [1:0] INTERNAL_FREQ_PICK,
    input wire logic WAKE_FROM_SLEEP,
    input wire logic OSCILLATOR_IN_PIN_I,
    input wire logic TIMER_CRYSTAL_IN_PIN_I,
    input wire logic GPIO_IN_PIN_O,
    input wire logic GPIO_IN_PIN_OE,
    input wire logic GPIO_OUT_PIN_O,
    input wire logic GPIO_OUT_PIN_OE,
    output logic SYS_CLK,
    output logic CPU_HOLD,
    output logic PLL_ENABLE,
    output logic INTERNAL_PLL_ACTIVE,
    output logic [1:0] AMP_GAIN,
    output logic OSCILLATOR_IN_PIN_O,
    output logic OSCILLATOR_IN_PIN_OE,
    output logic OSCILLATOR_OUT_PIN_O,
    output logic OSCILLATOR_OUT_PIN_OE,
    output logic [2:0] ACTIVE_SOURCE
);
    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [15:0] tune_ext(input logic [5:0] t);
        tune_ext = {{10{t[5]}}, t};
    endfunction

    function automatic logic is_crystal(input logic [2:0] m);
        is_crystal = (m == MODE_WATCH_XTAL) || (m == MODE_MEDIUM_XTAL) ||
                     (m == MODE_HIGH_XTAL);
    endfunction

    function automatic logic is_ext_logic(input logic [2:0] m);
        is_ext_logic = (m == MODE_EXT_LOW) || (m == MODE_EXT_MEDIUM) ||
                       (m == MODE_EXT_HIGH);
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    logic crystal_mode;
    logic ext_logic_mode;
    logic internal_mode;
    logic internal_select;
    logic pll_on;
    logic pll_internal;
    logic [15:0] mid_step;
    logic [15:0] hf_step;
    logic hf_level;
    logic mid_level;
    logic low_level;
    logic [4:0] src_level;
    logic [4:0] src_prev_reg;
    scss_src_e config_src;
    scss_src_e internal_src;
    scss_src_e req_src;
    scss_src_e cur_src_reg;
    scss_src_e tgt_src_reg;
    scss_sw_e state_reg;
    logic por_pending_reg;
    logic por_release;
    logic startup_start;
    logic release_no_count;
    logic osc_in_prev_reg;
    logic cur_level;
    logic tgt_rise;
    logic sys_clk_reg;
    logic [1:0] gain_reg;
    logic pin1_o_reg;
    logic pin1_oe_reg;
    logic pin2_o_reg;
    logic pin2_oe_reg;
    scss_startup_if su();

    // ************************************************************
    // mode decode
    // ************************************************************
    assign crystal_mode = is_crystal(OSC_MODE_CONFIG_FIELD);
    assign ext_logic_mode = is_ext_logic(OSC_MODE_CONFIG_FIELD);
    assign internal_mode = (OSC_MODE_CONFIG_FIELD == MODE_INTERNAL);
    assign internal_select = SYS_CLK_SELECT_FIELD[1];

    // ************************************************************
    // frequency multiplier enable
    // ************************************************************
    // configuration enable overrides software
    assign pll_on = CONFIG_PLL_ENABLE | SOFTWARE_PLL_ENABLE;
    // with the configuration bit set, pll_on is one regardless
    assign PLL_ENABLE = pll_on;
    // multiplier reaches the internal block only through the config path
    assign pll_internal = pll_on && internal_mode &&
                          (SYS_CLK_SELECT_FIELD == SEL_CONFIG);
    assign INTERNAL_PLL_ACTIVE = pll_internal;

    // ************************************************************
    // internal oscillator block
    // ************************************************************
    // tuning shifts the mid source, the high source tracks it
    assign mid_step = MID_STEP_BASE + tune_ext(OSCILLATOR_TUNING_REG);

    always_comb begin
        hf_step = mid_step << HF_LOOP_SHIFT;
        if (pll_internal) begin
            hf_step = mid_step << (HF_LOOP_SHIFT + PLL_SHIFT);
        end
    end

    scss_nco u_hf (
        .clk(CLK),
        .resetn(RESETN),
        .step(hf_step),
        .level(hf_level)
    );

    scss_nco u_mid (
        .clk(CLK),
        .resetn(RESETN),
        .step(mid_step),
        .level(mid_level)
    );

    // low source ignores tuning and has no calibration
    scss_nco u_low (
        .clk(CLK),
        .resetn(RESETN),
        .step(LOW_STEP),
        .level(low_level)
    );

    // ************************************************************
    // source request
    // ************************************************************
    always_comb begin
        if (INTERNAL_FREQ_PICK == INT_PICK_LOW) begin
            internal_src = SRC_LOW;
        end else if (INTERNAL_FREQ_PICK == INT_PICK_MID) begin
            internal_src = SRC_MID;
        end else begin
            internal_src = SRC_HF;
        end
    end

    always_comb begin
        if (internal_mode) begin
            config_src = internal_src;
        end else begin
            config_src = SRC_EXT;
        end
    end

    always_comb begin
        if (internal_select) begin
            req_src = internal_src;
        end else if (SYS_CLK_SELECT_FIELD == SEL_TIMER) begin
            req_src = SRC_TMR;
        end else begin
            req_src = config_src;
        end
    end

    // source levels; the external one passes straight through, so a
    // stopped input simply freezes the system clock with state intact
    assign src_level = {low_level, mid_level, hf_level,
                        TIMER_CRYSTAL_IN_PIN_I, OSCILLATOR_IN_PIN_I};

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            src_prev_reg <= SRC_RESET;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    assign cur_level = src_level[cur_src_reg];
    assign tgt_rise = src_level[tgt_src_reg] && !src_prev_reg[tgt_src_reg];

    // ************************************************************
    // start-up control
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            osc_in_prev_reg <= 1'b0;
        end else begin
            osc_in_prev_reg <= OSCILLATOR_IN_PIN_I;
        end
    end

    // power-on release waits for the power-up timer when configured
    assign por_release = por_pending_reg &&
                         (!POWER_UP_TIMER_CFG || POWER_UP_TIMER_DONE);

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            por_pending_reg <= 1'b1;
        end else if (por_release) begin
            por_pending_reg <= 1'b0;
        end
    end

    assign startup_start = crystal_mode &&
                           (por_release || WAKE_FROM_SLEEP);
    // external logic clock and the rest go without counting
    assign release_no_count = !crystal_mode && por_release;

    assign su.start = startup_start;
    assign su.osc_edge = OSCILLATOR_IN_PIN_I && !osc_in_prev_reg;

    scss_startup_counter u_startup (
        .clk(CLK),
        .resetn(RESETN),
        .su(su)
    );

    assign CPU_HOLD = su.busy || (state_reg == SW_STARTUP);

    // ************************************************************
    // glitch-free switch
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_reg <= SW_STARTUP;
        end else if (startup_start) begin
            state_reg <= SW_STARTUP;
        end else begin
            case (state_reg)
                SW_STARTUP: begin
                    if (su.done || release_no_count) begin
                        state_reg <= SW_NEW_RISE;
                    end
                end
                SW_RUN: begin
                    if (req_src != cur_src_reg) begin
                        state_reg <= SW_OLD_LOW;
                    end
                end
                SW_OLD_LOW: begin
                    if (!cur_level) begin
                        state_reg <= SW_NEW_RISE;
                    end
                end
                SW_NEW_RISE: begin
                    if (tgt_rise) begin
                        state_reg <= SW_RUN;
                    end
                end
                default: begin
                    state_reg <= SW_STARTUP;
                end
            endcase
        end
    end

    // target is latched when the old clock is seen low
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tgt_src_reg <= SRC_EXT;
        end else if (state_reg == SW_STARTUP) begin
            tgt_src_reg <= req_src;
        end else if (state_reg == SW_OLD_LOW && !cur_level) begin
            tgt_src_reg <= req_src;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cur_src_reg <= SRC_EXT;
        end else if (state_reg == SW_NEW_RISE && tgt_rise) begin
            cur_src_reg <= tgt_src_reg;
        end
    end

    // output follows the current source in run and while waiting for its low phase,
    // shows the target's first rise while waiting for it; held low in start-up
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sys_clk_reg <= 1'b0;
        end else if (startup_start) begin
            sys_clk_reg <= 1'b0;
        end else begin
            case (state_reg)
                SW_RUN: begin
                    sys_clk_reg <= cur_level;
                end
                SW_OLD_LOW: begin
                    sys_clk_reg <= cur_level;
                end
                SW_NEW_RISE: begin
                    sys_clk_reg <= tgt_rise;
                end
                default: begin
                    sys_clk_reg <= 1'b0;
                end
            endcase
        end
    end

    assign SYS_CLK = sys_clk_reg;
    assign ACTIVE_SOURCE = cur_src_reg;

    // ************************************************************
    // amplifier gain
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            gain_reg <= GAIN_OFF;
        end else begin
            case (OSC_MODE_CONFIG_FIELD)
                MODE_WATCH_XTAL: begin
                    gain_reg <= GAIN_LOWEST;
                end
                MODE_MEDIUM_XTAL: begin
                    gain_reg <= GAIN_MIDDLE;
                end
                MODE_HIGH_XTAL: begin
                    gain_reg <= GAIN_HIGHEST;
                end
                default: begin
                    gain_reg <= GAIN_OFF;
                end
            endcase
        end
    end

    assign AMP_GAIN = gain_reg;

    // ************************************************************
    // oscillator pins
    // ************************************************************
    // first pin is a clock input except in internal oscillator mode
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin1_o_reg <= 1'b0;
            pin1_oe_reg <= 1'b0;
        end else if (internal_mode) begin
            pin1_o_reg <= GPIO_IN_PIN_O;
            pin1_oe_reg <= GPIO_IN_PIN_OE;
        end else begin
            pin1_o_reg <= 1'b0;
            pin1_oe_reg <= 1'b0;
        end
    end

    // second pin belongs to the crystal amplifier in crystal modes
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin2_o_reg <= 1'b0;
            pin2_oe_reg <= 1'b0;
        end else if (crystal_mode) begin
            pin2_o_reg <= 1'b0;
            pin2_oe_reg <= 1'b0;
        end else if (!CLOCK_OUTPUT_ENABLE_N) begin
            pin2_o_reg <= sys_clk_reg;
            pin2_oe_reg <= 1'b1;
        end else begin
            pin2_o_reg <= GPIO_OUT_PIN_O;
            pin2_oe_reg <= GPIO_OUT_PIN_OE;
        end
    end

    assign OSCILLATOR_IN_PIN_O = pin1_o_reg;
    assign OSCILLATOR_IN_PIN_OE = pin1_oe_reg;
    assign OSCILLATOR_OUT_PIN_O = pin2_o_reg;
    assign OSCILLATOR_OUT_PIN_OE = pin2_oe_reg;
endmodule

/* core/scss_nco.sv */
// phase accumulator that models one internal oscillator as a level
`timescale 1ns/1ps
module scss_nco
    import scss_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] step,
    output logic level
);
    logic [15:0] phase_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase_reg <= 16'h0000;
        end else begin
            phase_reg <= phase_reg + step;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            level <= 1'b0;
        end else begin
            level <= phase_reg[15];
        end
    end
endmodule

/* core/scss_pkg.sv */
// constants and types for the system clock source select
package scss_pkg;
    localparam logic [2:0] MODE_WATCH_XTAL = 3'h0;
    localparam logic [2:0] MODE_MEDIUM_XTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_XTAL = 3'h2;
    localparam logic [2:0] MODE_RES_CAP = 3'h3;
    localparam logic [2:0] MODE_INTERNAL = 3'h4;
    localparam logic [2:0] MODE_EXT_LOW = 3'h5;
    localparam logic [2:0] MODE_EXT_MEDIUM = 3'h6;
    localparam logic [2:0] MODE_EXT_HIGH = 3'h7;
    localparam logic [1:0] SEL_CONFIG = 2'h0;
    localparam logic [1:0] SEL_TIMER = 2'h1;
    localparam logic [1:0] INT_PICK_LOW = 2'h0;
    localparam logic [1:0] INT_PICK_MID = 2'h1;
    localparam logic [1:0] GAIN_OFF = 2'h0;
    localparam logic [1:0] GAIN_LOWEST = 2'h1;
    localparam logic [1:0] GAIN_MIDDLE = 2'h2;
    localparam logic [1:0] GAIN_HIGHEST = 2'h3;
    localparam int STARTUP_CYCLES = 1024;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);
    localparam logic [15:0] MID_STEP_BASE = 16'h0148;
    localparam logic [15:0] LOW_STEP = 16'h0014;
    localparam int HF_LOOP_SHIFT = 5;
    localparam int PLL_SHIFT = 2;
    localparam logic [4:0] SRC_RESET = 5'h00;
    typedef enum logic [2:0] {
        SRC_EXT, SRC_TMR, SRC_HF, SRC_MID, SRC_LOW
    } scss_src_e;
    typedef enum logic [1:0] {
        SW_STARTUP, SW_RUN, SW_OLD_LOW, SW_NEW_RISE
    } scss_sw_e;
endpackage

/* core/scss_startup_counter.sv */
// counts oscillator input edges after a start request
`timescale 1ns/1ps
module scss_startup_counter
    import scss_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    scss_startup_if.counter su
);
    logic [10:0] count_reg;
    logic busy_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else if (su.start) begin
            busy_reg <= 1'b1;
        end else if (busy_reg && su.osc_edge && count_reg == STARTUP_LAST) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_reg <= 11'h000;
        end else if (su.start) begin
            count_reg <= 11'h000;
        end else if (busy_reg && su.osc_edge) begin
            count_reg <= count_reg + 11'h001;
        end
    end

    assign su.busy = busy_reg;
    assign su.done = busy_reg && su.osc_edge && count_reg == STARTUP_LAST;
endmodule

/* core/scss_startup_if.sv */
// start-up counter handshake between the selector and the counter
`timescale 1ns/1ps
interface scss_startup_if;
    logic start;
    logic osc_edge;
    logic busy;
    logic done;
    modport ctrl(output start, output osc_edge, input busy, input done);
    modport counter(input start, input osc_edge, output busy, output done);
endinterface

/* tb/scss_clock_select_props.sv */
// concurrent checks on the clock source selector ports
`timescale 1ns/1ps
module scss_clock_select_props
    import scss_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [2:0] OSC_MODE_CONFIG_FIELD,
    input wire logic CONFIG_PLL_ENABLE,
    input wire logic CLOCK_OUTPUT_ENABLE_N,
    input wire logic POWER_UP_TIMER_CFG,
    input wire logic [1:0] SYS_CLK_SELECT_FIELD,
    input wire logic SOFTWARE_PLL_ENABLE,
    input wire logic [1:0] INTERNAL_FREQ_PICK,
    input wire logic WAKE_FROM_SLEEP,
    input wire logic GPIO_IN_PIN_O,
    input wire logic GPIO_IN_PIN_OE,
    input wire logic GPIO_OUT_PIN_O,
    input wire logic GPIO_OUT_PIN_OE,
    input wire logic SYS_CLK,
    input wire logic CPU_HOLD,
    input wire logic PLL_ENABLE,
    input wire logic INTERNAL_PLL_ACTIVE,
    input wire logic [1:0] AMP_GAIN,
    input wire logic OSCILLATOR_IN_PIN_O,
    input wire logic OSCILLATOR_IN_PIN_OE,
    input wire logic OSCILLATOR_OUT_PIN_O,
    input wire logic OSCILLATOR_OUT_PIN_OE,
    input wire logic [2:0] ACTIVE_SOURCE
);
    // ****************************************
    // helpers
    // ****************************************
    logic [2:0] m;
    logic [1:0] gain_exp;
    logic [2:0] int_src;
    logic [2:0] req_src;
    logic [15:0] hold_cnt;
    logic xtal;
    assign m = OSC_MODE_CONFIG_FIELD;
    assign xtal = m <= MODE_HIGH_XTAL;
    assign gain_exp = m == MODE_WATCH_XTAL ? GAIN_LOWEST :
        m == MODE_MEDIUM_XTAL ? GAIN_MIDDLE :
        m == MODE_HIGH_XTAL ? GAIN_HIGHEST : GAIN_OFF;
    assign int_src = INTERNAL_FREQ_PICK == 2'h0 ? SRC_LOW :
        INTERNAL_FREQ_PICK == 2'h1 ? SRC_MID : SRC_HF;
    assign req_src = SYS_CLK_SELECT_FIELD == SEL_TIMER ? SRC_TMR :
        (SYS_CLK_SELECT_FIELD[1] || m == MODE_INTERNAL) ? int_src : SRC_EXT;
    always_ff @(posedge CLK) begin
        if (!RESETN || !CPU_HOLD) begin
            hold_cnt <= 16'h0000;
        end else if (hold_cnt != 16'hffff) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ****************************************
    // properties
    // ****************************************
    property p_pll;
        PLL_ENABLE == (CONFIG_PLL_ENABLE || SOFTWARE_PLL_ENABLE);
    endproperty
    a_pll: assert property (p_pll)
        else $error("multiplier enable is not the or of both enables");
    property p_int_pll;
        INTERNAL_PLL_ACTIVE == (PLL_ENABLE && m == MODE_INTERNAL &&
            SYS_CLK_SELECT_FIELD == SEL_CONFIG);
    endproperty
    a_int_pll: assert property (p_int_pll)
        else $error("internal multiplier use is wrong");
    property p_gain;
        1'b1 |=> AMP_GAIN == $past(gain_exp);
    endproperty
    a_gain: assert property (p_gain)
        else $error("amplifier gain does not follow mode");
    property p_clock_output_function;
        !xtal && !CLOCK_OUTPUT_ENABLE_N |=> OSCILLATOR_OUT_PIN_OE &&
            OSCILLATOR_OUT_PIN_O == $past(SYS_CLK);
    endproperty
    a_clock_output_function: assert property (p_clock_output_function)
        else $error("second pin does not carry the clock");
    property p_gpio2;
        !xtal && CLOCK_OUTPUT_ENABLE_N |=> OSCILLATOR_OUT_PIN_OE ==
            $past(GPIO_OUT_PIN_OE) && OSCILLATOR_OUT_PIN_O ==
            $past(GPIO_OUT_PIN_O);
    endproperty
    a_gpio2: assert property (p_gpio2)
        else $error("second pin is not general purpose");
    property p_gpio1;
        m == MODE_INTERNAL |=> OSCILLATOR_IN_PIN_OE == $past(GPIO_IN_PIN_OE)
            && OSCILLATOR_IN_PIN_O == $past(GPIO_IN_PIN_O);
    endproperty
    a_gpio1: assert property (p_gpio1)
        else $error("first pin is not released in internal mode");
    property p_hold_low;
        CPU_HOLD && $past(CPU_HOLD) |-> !SYS_CLK;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("system clock runs while held");
    property p_wake;
        WAKE_FROM_SLEEP && xtal |=> CPU_HOLD;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake does not restart the start-up count");
    property p_wake_ext;
        WAKE_FROM_SLEEP && m >= MODE_EXT_LOW && !CPU_HOLD |=> !CPU_HOLD;
    endproperty
    a_wake_ext: assert property (p_wake_ext)
        else $error("wake delays external clock mode");
    property p_ext_start;
        $rose(RESETN) && m >= MODE_EXT_LOW && !POWER_UP_TIMER_CFG
            |-> ##[1:40] !CPU_HOLD;
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("external clock mode start is delayed");
    property p_count;
        $fell(CPU_HOLD) && xtal |-> hold_cnt >= 16'd2000;
    endproperty
    a_count: assert property (p_count)
        else $error("crystal start-up released too early");
    property p_src;
        $changed(ACTIVE_SOURCE) |-> ACTIVE_SOURCE == $past(req_src);
    endproperty
    a_src: assert property (p_src)
        else $error("active source differs from the request");
    property p_switch_edge;
        $changed(ACTIVE_SOURCE) |-> $rose(SYS_CLK);
    endproperty
    a_switch_edge: assert property (p_switch_edge)
        else $error("new source does not start on a clean rising edge");
endmodule
bind scss_clock_select scss_clock_select_props u_props(.CLK(CLK),
    .RESETN(RESETN), .OSC_MODE_CONFIG_FIELD(OSC_MODE_CONFIG_FIELD),
    .CONFIG_PLL_ENABLE(CONFIG_PLL_ENABLE),
    .CLOCK_OUTPUT_ENABLE_N(CLOCK_OUTPUT_ENABLE_N),
    .POWER_UP_TIMER_CFG(POWER_UP_TIMER_CFG),
    .SYS_CLK_SELECT_FIELD(SYS_CLK_SELECT_FIELD),
    .SOFTWARE_PLL_ENABLE(SOFTWARE_PLL_ENABLE),
    .INTERNAL_FREQ_PICK(INTERNAL_FREQ_PICK),
    .WAKE_FROM_SLEEP(WAKE_FROM_SLEEP), .GPIO_IN_PIN_O(GPIO_IN_PIN_O),
    .GPIO_IN_PIN_OE(GPIO_IN_PIN_OE), .GPIO_OUT_PIN_O(GPIO_OUT_PIN_O),
    .GPIO_OUT_PIN_OE(GPIO_OUT_PIN_OE), .SYS_CLK(SYS_CLK),
    .CPU_HOLD(CPU_HOLD), .PLL_ENABLE(PLL_ENABLE),
    .INTERNAL_PLL_ACTIVE(INTERNAL_PLL_ACTIVE), .AMP_GAIN(AMP_GAIN),
    .OSCILLATOR_IN_PIN_O(OSCILLATOR_IN_PIN_O),
    .OSCILLATOR_IN_PIN_OE(OSCILLATOR_IN_PIN_OE),
    .OSCILLATOR_OUT_PIN_O(OSCILLATOR_OUT_PIN_O),
    .OSCILLATOR_OUT_PIN_OE(OSCILLATOR_OUT_PIN_OE),
    .ACTIVE_SOURCE(ACTIVE_SOURCE));

/* tb/scss_clock_select_tb_top.sv */
// self-checking testbench for the clock source selector
`timescale 1ns/1ps
module scss_clock_select_tb_top
    import scss_pkg::*;
;
    logic clk, resetn, cfg_pll, clock_output_function_n, put_cfg, put_done, sw_pll, wake;
    logic osc_in, tmr_in, g1_o, g1_oe, g2_o, g2_oe, ext_run, sys_clk, hold;
    logic pll_en, ipll, p1_o, p1_oe, p2_o, p2_oe, s;
    logic [2:0] mode, src;
    logic [1:0] sel, pick, gain;
    logic [5:0] tune;
    int bad_count, comparisons, n;
    always #5 clk = ~clk;
    scss_osc_model #(.HALF_NS(37.0)) u_ext(.run(ext_run), .level(osc_in));
    scss_osc_model #(.HALF_NS(230.0)) u_tmr(.run(1'b1), .level(tmr_in));
    scss_clock_select dut(.CLK(clk), .RESETN(resetn),
        .OSC_MODE_CONFIG_FIELD(mode), .CONFIG_PLL_ENABLE(cfg_pll),
        .CLOCK_OUTPUT_ENABLE_N(clock_output_function_n), .POWER_UP_TIMER_CFG(put_cfg),
        .POWER_UP_TIMER_DONE(put_done), .SYS_CLK_SELECT_FIELD(sel),
        .SOFTWARE_PLL_ENABLE(sw_pll), .OSCILLATOR_TUNING_REG(tune),
        .INTERNAL_FREQ_PICK(pick), .WAKE_FROM_SLEEP(wake),
        .OSCILLATOR_IN_PIN_I(osc_in), .TIMER_CRYSTAL_IN_PIN_I(tmr_in),
        .GPIO_IN_PIN_O(g1_o), .GPIO_IN_PIN_OE(g1_oe), .GPIO_OUT_PIN_O(g2_o),
        .GPIO_OUT_PIN_OE(g2_oe), .SYS_CLK(sys_clk), .CPU_HOLD(hold),
        .PLL_ENABLE(pll_en), .INTERNAL_PLL_ACTIVE(ipll), .AMP_GAIN(gain),
        .OSCILLATOR_IN_PIN_O(p1_o), .OSCILLATOR_IN_PIN_OE(p1_oe),
        .OSCILLATOR_OUT_PIN_O(p2_o), .OSCILLATOR_OUT_PIN_OE(p2_oe),
        .ACTIVE_SOURCE(src));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({2'h0, got}, {2'h0, exp});
    endtask
    task automatic do_reset(input logic [2:0] m);
        resetn = 1'b0;
        mode = m;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
    endtask
    task automatic wait_src(input logic [2:0] exp);
        for (int i = 0; i < 12000 && src !== exp; i++) @(negedge clk);
        chk_val(src, exp);
        if (src !== exp) wrap_up();
    endtask
    // counts oscillator rises until the hold is lifted
    task automatic count_rises;
        logic prev;
        n = 0;
        prev = osc_in;
        for (int i = 0; i < 30000 && hold !== 1'b0; i++) begin
            @(negedge clk);
            if (osc_in && !prev) n++;
            prev = osc_in;
        end
        chk_bit(hold, 1'b0);
        if (hold !== 1'b0) wrap_up();
    endtask
    task automatic pulse_wake;
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            {g1_o, g2_o} = 2'(m);
            repeat (3) @(negedge clk);
            chk_val({1'b0, gain}, m < 3 ? 3'(m + 1) : 3'h0);
            chk_bit(p2_oe, m > 2);
            chk_bit(p1_oe, m == 4);
        end
    endtask
    task automatic t_ext;
        do_reset(MODE_EXT_HIGH);
        for (int i = 0; i < 40 && hold !== 1'b0; i++) @(negedge clk);
        chk_bit(hold, 1'b0);
        if (hold !== 1'b0) wrap_up();
        chk_val(src, SRC_EXT);
        pulse_wake();
        chk_bit(hold, 1'b0);
        ext_run = 1'b0;
        repeat (20) @(negedge clk);
        s = sys_clk;
        repeat (50) @(negedge clk);
        chk_bit(sys_clk, s);
        ext_run = 1'b1;
        for (int i = 0; i < 50 && sys_clk === s; i++) @(negedge clk);
        chk_bit(sys_clk, ~s);
        clock_output_function_n = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit(p2_oe, 1'b1);
        clock_output_function_n = 1'b1;
        sel = SEL_TIMER;
        wait_src(SRC_TMR);
        sel = 2'h2;
        wait_src(SRC_LOW);
        pick = INT_PICK_MID;
        wait_src(SRC_MID);
        pick = 2'h2;
        wait_src(SRC_HF);
        sel = SEL_CONFIG;
        wait_src(SRC_EXT);
    endtask
    task automatic t_int;
        pick = INT_PICK_MID;
        do_reset(MODE_INTERNAL);
        wait_src(SRC_MID);
        sw_pll = 1'b1;
        @(negedge clk);
        chk_bit(pll_en, 1'b1);
        chk_bit(ipll, 1'b1);
        sel = 2'h3;
        @(negedge clk);
        chk_bit(ipll, 1'b0);
        sel = SEL_CONFIG;
        sw_pll = 1'b0;
        cfg_pll = 1'b1;
        @(negedge clk);
        chk_bit(pll_en, 1'b1);
        cfg_pll = 1'b0;
        @(negedge clk);
        chk_bit(pll_en, 1'b0);
    endtask
    task automatic t_xtal;
        put_cfg = 1'b1;
        do_reset(MODE_MEDIUM_XTAL);
        repeat (200) @(negedge clk);
        chk_bit(hold, 1'b1);
        put_done = 1'b1;
        count_rises();
        chk_bit(n >= 1023 && n <= 1026, 1'b1);
        pulse_wake();
        chk_bit(hold, 1'b1);
        count_rises();
        chk_bit(n >= 1023 && n <= 1026, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        mode = MODE_EXT_HIGH;
        {cfg_pll, put_cfg, put_done, sw_pll, wake} = 5'h00;
        {clock_output_function_n, g1_o, g1_oe, g2_o, g2_oe, ext_run} = 6'h3f;
        sel = SEL_CONFIG;
        pick = INT_PICK_LOW;
        tune = 6'h00;
        bad_count = 0;
        comparisons = 0;
        @(negedge clk);
        t_modes();
        t_ext();
        t_int();
        t_xtal();
        wrap_up();
    end
endmodule

/* tb/scss_osc_model.sv */
// behavioural external oscillator or crystal seen at an oscillator pin
`timescale 1ns/1ps
module scss_osc_model #(
    parameter real HALF_NS = 37.0
) (
    input wire logic run,
    output logic level
);
    // ****************************************
    // oscillation
    // ****************************************
    // edges sit on odd picoseconds so they never meet a clock edge
    initial begin
        level = 1'b0;
        #0.001;
        forever begin
            #(HALF_NS);
            // a stopped source holds its level, like a halted generator
            if (run) begin
                level = ~level;
            end
        end
    end
endmodule
